// ---- verilog/mode_regs_pkg.sv ----
// Purpose: shared constants for the encoder mode register bank
// Assumes: byte-wide registers addressed by a 5-bit register index
// Notes: offsets and field positions are used by the bank, widths by the delay line
`default_nettype none
package mode_regs_pkg;
	localparam logic [4:0] PATH_DELAY_OFFSET = 5'h02;
	localparam logic [4:0] MODE_DAC_OFFSET = 5'h03;
	localparam logic [4:0] RESTART_OFFSET = 5'h04;
	localparam logic [4:0] FORMAT_OFFSET = 5'h05;
	localparam logic [7:0] PATH_DELAY_RESET = 8'h00;
	localparam logic [7:0] MODE_DAC_RESET = 8'h00;
	localparam logic [7:0] RESTART_RESET = 8'h00;
	localparam logic [7:0] FORMAT_RESET = 8'h00;
	localparam int LUMA_DELAY_LSB = 0;
	localparam int CHROMA_DELAY_LSB = 3;
	localparam int HD_SELECT_BIT = 0;
	localparam int DAC_A_ON_BIT = 3;
	localparam int DAC_B_ON_BIT = 4;
	localparam int DAC_C_ON_BIT = 5;
	localparam int RESTART_BIT = 0;
	localparam int REVISION_BIT = 0;
	localparam int RGB_SELECT_BIT = 1;
	localparam int SYNC_INSERT_BIT = 2;
	localparam int DAC_SWAP_BIT = 3;
	localparam int DELAY_W = 3;
	localparam int MAX_DELAY = 4;
	localparam int PIX_W = 10;
	// arbitrary neutral revision value
	localparam logic REVISION_CODE = 1'b0;
	// writable bit masks, reserved bits read back as zero
	localparam logic [7:0] PATH_DELAY_MASK = 8'h3F;
	localparam logic [7:0] MODE_DAC_MASK = 8'h39;
	localparam logic [7:0] RESTART_MASK = 8'h01;
	localparam logic [7:0] FORMAT_MASK = 8'h0E;
	// sync tip level inserted on colour-difference outputs
	localparam logic [9:0] CHROMA_SYNC_LEVEL = 10'h040;
endpackage : mode_regs_pkg
`default_nettype wire

// ---- verilog/pixel_delay_line.sv ----
// Purpose: programmable 0..4 pixel delay of one component path
// Assumes: delay code is stable while video runs
// Notes: codes above four clamp to the longest tap
`default_nettype none
module pixel_delay_line (
	input wire logic i_mclk, // pixel clock
	input wire logic i_srst, // synchronous reset
	input wire logic [mode_regs_pkg::DELAY_W-1:0] i_delay, // delay in pixel clocks
	input wire logic [mode_regs_pkg::PIX_W-1:0] i_pix, // input sample
	output logic [mode_regs_pkg::PIX_W-1:0] o_pix // delayed sample, combinational tap
);
	logic [mode_regs_pkg::PIX_W-1:0] tap_reg [1:mode_regs_pkg::MAX_DELAY];
	wire logic [mode_regs_pkg::DELAY_W-1:0] sel;

	// out-of-range codes clamp so the output never goes undefined
	assign sel = (i_delay > 3'(mode_regs_pkg::MAX_DELAY)) ? 3'(mode_regs_pkg::MAX_DELAY) : i_delay;
	// code zero passes the undelayed sample, so the chain itself holds no tap zero
	assign o_pix = (sel == 3'h0) ? i_pix : tap_reg[sel];

	// shift chain, one stage per pixel clock
	genvar g;
	generate
		for (g = 1; g <= mode_regs_pkg::MAX_DELAY; g++) begin : g_tap
			if (g == 1) begin : g_first
				always_ff @(posedge i_mclk) begin
					if (i_srst) begin
						tap_reg[g] <= '0;
					end else begin
						tap_reg[g] <= i_pix;
					end
				end
			end else begin : g_next
				always_ff @(posedge i_mclk) begin
					if (i_srst) begin
						tap_reg[g] <= '0;
					end else begin
						tap_reg[g] <= tap_reg[g-1];
					end
				end
			end
		end
	endgenerate
endmodule : pixel_delay_line
`default_nettype wire

// ---- verilog/mode_ctrl_regs.sv ----
// Purpose: four encoder mode registers and the video path settings they steer
// Assumes: the serial port decoder presents byte writes and reads on i_mclk
// Notes: delays are relative to the horizontal sync falling edge
//
// Behaviour
// - luma is delayed by the luma delay code, zero to four pixel clocks.
// - both colour-difference paths are delayed by the chroma delay code, zero to four clocks.
// - hd select one means HDTV mode, zero means progressive scan.
// - each DAC enable bit powers its DAC on when one and down when zero.
// - a low-high-low pulse on the restart bit resets the timing counters.
// - rgb input select makes the input port take unsigned RGB, also in async timing.
// - sync pulses go on colour-difference outputs only when enabled and never in RGB.
// - DAC B carries red difference and DAC C blue, exchanged when swap is one.
// - the lowest format bit reads the revision code, not a setting.
// - in async timing, the sync inputs mark horizontal edges and active video.
`default_nettype none
module mode_ctrl_regs (
	input wire logic i_mclk, // pixel clock, 250 MHz
	input wire logic i_srst, // synchronous reset, active high
	input wire logic i_wr_en, // register write strobe from the serial port
	input wire logic i_rd_en, // register read strobe from the serial port
	input wire logic [4:0] i_addr, // register index
	input wire logic [7:0] i_wdata, // write data
	output logic [7:0] o_rdata, // read data, valid the cycle after i_rd_en
	input wire logic i_hsync_n, // horizontal sync pin, falling edge starts line
	input wire logic i_trilevel_sync_input, // tri-level sync marker pin
	input wire logic i_data_valid_input, // active video marker pin
	input wire logic [9:0] i_pix_y, // luma or green sample
	input wire logic [9:0] i_pix_cr, // red difference or red sample
	input wire logic [9:0] i_pix_cb, // blue difference or blue sample
	output logic [9:0] o_dac_a, // DAC A code
	output logic [9:0] o_dac_b, // DAC B code
	output logic [9:0] o_dac_c, // DAC C code
	output logic o_dac_a_on, // DAC A powered
	output logic o_dac_b_on, // DAC B powered
	output logic o_dac_c_on, // DAC C powered
	output logic o_hd_mode, // 1 HDTV, 0 progressive scan
	output logic o_rgb_mode, // input port carries RGB
	output logic o_timing_restart, // one-cycle counter reset pulse
	output logic o_line_start, // pulse at horizontal sync falling edge
	output logic o_active_video // active video window from data valid
);
	logic [7:0] delay_reg;
	logic [7:0] mode_reg;
	logic [7:0] restart_reg;
	logic [7:0] format_reg;
	logic restart_seen_reg;
	logic [2:0] hs_sync_reg;
	logic [1:0] ts_sync_reg;
	logic [1:0] dv_sync_reg;
	logic hs_prev_reg;
	logic [9:0] y_d;
	logic [9:0] cr_d;
	logic [9:0] cb_d;

	wire logic wr_delay;
	wire logic wr_mode;
	wire logic wr_restart;
	wire logic wr_format;
	wire logic [7:0] rd_mux;
	wire logic hs_fall;
	wire logic restart_done;
	wire logic sync_insert;
	wire logic [9:0] pr_out;
	wire logic [9:0] pb_out;

	// address decode for the four mode registers
	assign wr_delay = i_wr_en && (i_addr == mode_regs_pkg::PATH_DELAY_OFFSET);
	assign wr_mode = i_wr_en && (i_addr == mode_regs_pkg::MODE_DAC_OFFSET);
	assign wr_restart = i_wr_en && (i_addr == mode_regs_pkg::RESTART_OFFSET);
	assign wr_format = i_wr_en && (i_addr == mode_regs_pkg::FORMAT_OFFSET);

	// read mux; the format low bit always shows the revision code
	assign rd_mux = (i_addr == mode_regs_pkg::PATH_DELAY_OFFSET) ? delay_reg :
		(i_addr == mode_regs_pkg::MODE_DAC_OFFSET) ? mode_reg :
		(i_addr == mode_regs_pkg::RESTART_OFFSET) ? restart_reg :
		(i_addr == mode_regs_pkg::FORMAT_OFFSET) ?
		{format_reg[7:1], mode_regs_pkg::REVISION_CODE} : 8'h00;

	// register writes; reserved bits are masked off since hosts may not clear them
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			delay_reg <= mode_regs_pkg::PATH_DELAY_RESET;
			mode_reg <= mode_regs_pkg::MODE_DAC_RESET;
			restart_reg <= mode_regs_pkg::RESTART_RESET;
			format_reg <= mode_regs_pkg::FORMAT_RESET;
		end else begin
			if (wr_delay) delay_reg <= i_wdata & mode_regs_pkg::PATH_DELAY_MASK;
			if (wr_mode) mode_reg <= i_wdata & mode_regs_pkg::MODE_DAC_MASK;
			if (wr_restart) restart_reg <= i_wdata & mode_regs_pkg::RESTART_MASK;
			if (wr_format) format_reg <= i_wdata & mode_regs_pkg::FORMAT_MASK;
		end
	end

	// read data register
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_rdata <= 8'h00;
		end else if (i_rd_en) begin
			o_rdata <= rd_mux;
		end
	end

	// restart completes only when the bit returns low after having been high
	assign restart_done = restart_seen_reg && !restart_reg[mode_regs_pkg::RESTART_BIT];

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			restart_seen_reg <= 1'b0;
			o_timing_restart <= 1'b0;
		end else begin
			if (restart_reg[mode_regs_pkg::RESTART_BIT]) begin
				restart_seen_reg <= 1'b1;
			end else begin
				restart_seen_reg <= 1'b0;
			end
			o_timing_restart <= restart_done;
		end
	end

	// pin synchronisers; only the second stage is read by logic
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			hs_sync_reg <= 3'h7;
			ts_sync_reg <= 2'h0;
			dv_sync_reg <= 2'h0;
			hs_prev_reg <= 1'b1;
		end else begin
			hs_sync_reg <= {hs_sync_reg[1:0], i_hsync_n};
			ts_sync_reg <= {ts_sync_reg[0], i_trilevel_sync_input};
			dv_sync_reg <= {dv_sync_reg[0], i_data_valid_input};
			hs_prev_reg <= hs_sync_reg[1];
		end
	end

	assign hs_fall = hs_prev_reg && !hs_sync_reg[1];

	// line start and active window markers for the timing logic
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_line_start <= 1'b0;
			o_active_video <= 1'b0;
		end else begin
			o_line_start <= hs_fall;
			o_active_video <= hs_sync_reg[1] && dv_sync_reg[1];
		end
	end

	// per-path delay relative to the sync edge
	pixel_delay_line u_dly_y (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_delay(delay_reg[mode_regs_pkg::LUMA_DELAY_LSB +: 3]),
		.i_pix(i_pix_y),
		.o_pix(y_d)
	);
	pixel_delay_line u_dly_cr (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_delay(delay_reg[mode_regs_pkg::CHROMA_DELAY_LSB +: 3]),
		.i_pix(i_pix_cr),
		.o_pix(cr_d)
	);
	pixel_delay_line u_dly_cb (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_delay(delay_reg[mode_regs_pkg::CHROMA_DELAY_LSB +: 3]),
		.i_pix(i_pix_cb),
		.o_pix(cb_d)
	);

	// sync tip goes on the colour-difference outputs while horizontal sync is low
	assign sync_insert = format_reg[mode_regs_pkg::SYNC_INSERT_BIT] &&
		!format_reg[mode_regs_pkg::RGB_SELECT_BIT] && !hs_sync_reg[1];
	assign pr_out = sync_insert ? mode_regs_pkg::CHROMA_SYNC_LEVEL : cr_d;
	assign pb_out = sync_insert ? mode_regs_pkg::CHROMA_SYNC_LEVEL : cb_d;

	// DAC data; a powered-down DAC is held at zero code
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_dac_a <= 10'h000;
			o_dac_b <= 10'h000;
			o_dac_c <= 10'h000;
		end else begin
			o_dac_a <= mode_reg[mode_regs_pkg::DAC_A_ON_BIT] ? y_d : 10'h000;
			if (!mode_reg[mode_regs_pkg::DAC_B_ON_BIT]) begin
				o_dac_b <= 10'h000;
			end else if (format_reg[mode_regs_pkg::DAC_SWAP_BIT]) begin
				o_dac_b <= pb_out;
			end else begin
				o_dac_b <= pr_out;
			end
			if (!mode_reg[mode_regs_pkg::DAC_C_ON_BIT]) begin
				o_dac_c <= 10'h000;
			end else if (format_reg[mode_regs_pkg::DAC_SWAP_BIT]) begin
				o_dac_c <= pr_out;
			end else begin
				o_dac_c <= pb_out;
			end
		end
	end

	// mode outputs registered so they change two cycles after the write
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_dac_a_on <= 1'b0;
			o_dac_b_on <= 1'b0;
			o_dac_c_on <= 1'b0;
			o_hd_mode <= 1'b0;
			o_rgb_mode <= 1'b0;
		end else begin
			o_dac_a_on <= mode_reg[mode_regs_pkg::DAC_A_ON_BIT];
			o_dac_b_on <= mode_reg[mode_regs_pkg::DAC_B_ON_BIT];
			o_dac_c_on <= mode_reg[mode_regs_pkg::DAC_C_ON_BIT];
			o_hd_mode <= mode_reg[mode_regs_pkg::HD_SELECT_BIT];
			o_rgb_mode <= format_reg[mode_regs_pkg::RGB_SELECT_BIT];
		end
	end

	// trilevel marker is synchronised for the async timing generator; unused here otherwise
	wire logic unused_ts;
	assign unused_ts = ts_sync_reg[1];
endmodule : mode_ctrl_regs
`default_nettype wire

// ---- dv/host_timing_model.sv ----
// Purpose: host-side timing pin source for the mode register tests
// Assumes: requests change only at the pixel clock rising edge
// Notes: data valid rises only while sync is high, never across a sync edge
`default_nettype none
module host_timing_model (
	input wire logic i_mclk, // pixel clock
	input wire logic i_sync_req, // hold sync low while set
	input wire logic i_active_req, // ask for active video
	output logic o_hsync_n, // sync pin
	output logic o_trilevel, // tri-level marker
	output logic o_dv // data valid pin
);
	// idle line: sync high, markers low
	initial begin
		o_hsync_n = 1'b1;
		o_trilevel = 1'b0;
		o_dv = 1'b0;
	end
	// marker rises a cycle into the sync low phase; valid is dropped on the same edge that sync falls
	always @(posedge i_mclk) begin
		o_hsync_n <= !i_sync_req;
		o_trilevel <= !o_hsync_n;
		o_dv <= i_active_req && o_hsync_n && !i_sync_req;
	end
endmodule : host_timing_model
`default_nettype wire

// ---- dv/mode_ctrl_regs_sva.sv ----
// Purpose: port checks for the mode register bank
// Assumes: one clock domain, synchronous reset
// Notes: mode outputs follow a write by two cycles
`default_nettype none
module mode_ctrl_regs_sva (
	input wire logic i_mclk, // clock
	input wire logic i_srst, // reset
	input wire logic i_wr_en, // write
	input wire logic i_rd_en, // read
	input wire logic [4:0] i_addr, // index
	input wire logic [7:0] i_wdata, // data
	input wire logic [7:0] o_rdata, // read data
	input wire logic i_hsync_n, // sync pin
	input wire logic o_dac_a_on, // on a
	input wire logic o_dac_b_on, // on b
	input wire logic o_dac_c_on, // on c
	input wire logic o_hd_mode, // hd
	input wire logic o_rgb_mode, // rgb
	input wire logic o_timing_restart, // restart
	input wire logic o_line_start // line
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_srst);
	// decoded strobes; unmapped means outside the four registers
	wire logic wr3 = i_wr_en && i_addr == 5'h03;
	wire logic wr5 = i_wr_en && i_addr == 5'h05;
	wire logic unm = i_addr < 5'h02 || i_addr > 5'h05;
	property p_hd; wr3 |-> ##2 o_hd_mode == $past(i_wdata[0], 2); endproperty
	a_hd: assert property (p_hd) else $error("hd mode wrong");
	property p_dac; wr3 |-> ##2 {o_dac_c_on, o_dac_b_on, o_dac_a_on} == $past(i_wdata[5:3], 2); endproperty
	a_dac: assert property (p_dac) else $error("dac enable wrong");
	property p_rgb; wr5 |-> ##2 o_rgb_mode == $past(i_wdata[1], 2); endproperty
	a_rgb: assert property (p_rgb) else $error("rgb mode wrong");
	property p_rs; o_timing_restart |-> $past(i_wr_en && i_addr == 5'h04 && !i_wdata[0], 2); endproperty
	a_rs: assert property (p_rs) else $error("restart without cause");
	property p_rs1; o_timing_restart |=> !o_timing_restart; endproperty
	a_rs1: assert property (p_rs1) else $error("restart too long");
	property p_ls; $fell(i_hsync_n) ##1 !i_hsync_n |-> ##[1:4] o_line_start; endproperty
	a_ls: assert property (p_ls) else $error("line start missing");
	property p_unm; i_rd_en && unm |=> o_rdata == 8'h00; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	property p_fmt; i_rd_en && i_addr == 5'h05 |=> o_rdata[0] == 1'b0 && o_rdata[7:4] == 4'h0; endproperty
	a_fmt: assert property (p_fmt) else $error("format read wrong");
endmodule : mode_ctrl_regs_sva
bind mode_ctrl_regs mode_ctrl_regs_sva u_mode_ctrl_regs_sva (.i_mclk, .i_srst, .i_wr_en, .i_rd_en,
	.i_addr, .i_wdata, .o_rdata, .i_hsync_n, .o_dac_a_on, .o_dac_b_on, .o_dac_c_on, .o_hd_mode,
	.o_rgb_mode, .o_timing_restart, .o_line_start);
`default_nettype wire

// ---- dv/mode_ctrl_regs_test.sv ----
// Purpose: directed register and video path tests for the mode register bank
// Assumes: reads answer one cycle after the strobe
// Notes: pixel inputs carry a cycle count so delays read off directly
`default_nettype none
module mode_ctrl_regs_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_mclk, i_srst, i_wr_en, i_rd_en, sreq, areq, hs_n, tls, dv;
	logic [4:0] i_addr;
	logic [7:0] i_wdata, o_rdata;
	logic [9:0] cnt, a, b, c;
	logic aon, bon, con, hd, rgb, rs, ls, av;
	logic [7:0] msk [4] = '{8'h3F, 8'h39, 8'h01, 8'h0E};
	int n_mismatch, cmp_count, nrs, nls;
	host_timing_model u_host_timing_model (.i_mclk, .i_sync_req(sreq), .i_active_req(areq),
		.o_hsync_n(hs_n), .o_trilevel(tls), .o_dv(dv));
	mode_ctrl_regs u_mode_ctrl_regs (.i_mclk, .i_srst, .i_wr_en, .i_rd_en, .i_addr, .i_wdata,
		.o_rdata, .i_hsync_n(hs_n), .i_trilevel_sync_input(tls), .i_data_valid_input(dv),
		.i_pix_y(cnt), .i_pix_cr(cnt + 10'h100), .i_pix_cb(cnt + 10'h200), .o_dac_a(a),
		.o_dac_b(b), .o_dac_c(c), .o_dac_a_on(aon), .o_dac_b_on(bon), .o_dac_c_on(con),
		.o_hd_mode(hd), .o_rgb_mode(rgb), .o_timing_restart(rs), .o_line_start(ls),
		.o_active_video(av));
	// clock, and pixel count plus pulse counters
	initial begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		cnt <= cnt + 10'h001;
		nrs <= nrs + int'(rs === 1'b1);
		nls <= nls + int'(ls === 1'b1);
	end
	task automatic chk(input string nm, input logic [9:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [4:0] ad, input logic [7:0] d);
		@(posedge i_mclk);
		i_wr_en <= 1'b1;
		i_addr <= ad;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] ad, input logic [7:0] e);
		@(posedge i_mclk);
		i_rd_en <= 1'b1;
		i_addr <= ad;
		@(posedge i_mclk);
		i_rd_en <= 1'b0;
		@(posedge i_mclk);
		#1;
		chk("rdata", {2'b00, o_rdata}, {2'b00, e});
	endtask : rd
	// settle delay lines and pulses, then look between edges
	task automatic wt(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask : wt
	task automatic pix(input logic [9:0] ea, eb, ec);
		wt(1);
		chk("dac_a", a, cnt + ea);
		chk("dac_b", b, cnt + eb);
		chk("dac_c", c, cnt + ec);
	endtask : pix
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test
	// a hang anywhere ends the run as a failure
	initial begin
		#20000;
		n_mismatch++;
		end_of_test();
	end
	initial begin
		{i_srst, i_wr_en, i_rd_en, sreq, areq} = 5'b10000;
		{i_addr, i_wdata, cnt} = '0;
		{n_mismatch, cmp_count, nrs, nls} = '0;
		repeat (16) @(posedge i_mclk);
		i_srst <= 1'b0;
		for (int k = 0; k < 4; k++) rd(5'(k + 2), 8'h00);
		// reserved and revision bits read back zero; unmapped space stays empty
		for (int k = 0; k < 4; k++) begin
			wr(5'(k + 2), 8'hFF);
			rd(5'(k + 2), msk[k]);
		end
		wr(5'h06, 8'hFF);
		rd(5'h06, 8'h00);
		rd(5'h1F, 8'h00);
		wt(2);
		chk("modes", {hd, aon, bon, con}, 10'h00F);
		chk("restart", 10'(nrs), 10'h000);
		wr(5'h04, 8'h00);
		wr(5'h04, 8'h01);
		wr(5'h04, 8'h00);
		wt(3);
		chk("restart", 10'(nrs), 10'h002);
		wr(5'h05, 8'h00);
		// luma and chroma delays across every legal code
		for (int n = 0; n <= 4; n++) begin
			wr(5'h02, 8'((4 - n) * 8 + n));
			wt(6);
			pix(10'h3FF - 10'(n), 10'h0FB + 10'(n), 10'h1FB + 10'(n));
		end
		wr(5'h05, 8'h08);
		pix(10'h3FB, 10'h1FF, 10'h0FF);
		wr(5'h05, 8'h04);
		sreq <= 1'b1;
		wt(8);
		chk("dac_b", b, 10'h040);
		chk("dac_c", c, 10'h040);
		chk("line", 10'(nls), 10'h001);
		wr(5'h05, 8'h06);
		wt(3);
		chk("rgb", 10'(rgb), 10'h001);
		pix(10'h3FB, 10'h0FF, 10'h1FF);
		sreq <= 1'b0;
		areq <= 1'b1;
		wt(8);
		chk("active", 10'(av), 10'h001);
		wr(5'h03, 8'h08);
		wt(3);
		chk("modes", {hd, aon, bon, con}, 10'h004);
		chk("dac_b", b, 10'h000);
		end_of_test();
	end
endmodule : mode_ctrl_regs_test
`default_nettype wire
